// ### verilog/aiss_pkg.sv
package aiss_pkg;
    // ------------------------------------------------------------
    // register map (byte addresses on the AHB-Lite slave)
    // ------------------------------------------------------------
    localparam logic [7:0] AISS_OFS_CHSEL = 8'h00;
    localparam logic [7:0] AISS_OFS_SCANH = 8'h04;
    localparam logic [7:0] AISS_OFS_SCANL = 8'h08;
    localparam logic [7:0] AISS_OFS_CTRL = 8'h0C;
    localparam logic [7:0] AISS_OFS_STAT = 8'h10;

    // ------------------------------------------------------------
    // reset values and field layouts
    // ------------------------------------------------------------
    localparam logic [15:0] AISS_RST_CHSEL = 16'h0000;
    localparam logic [15:0] AISS_RST_SCAN = 16'h0000;
    localparam logic [15:0] AISS_SCANH_MASK = 16'hC700;
    localparam logic [15:0] AISS_CHSEL_MASK = 16'h9F9F;
    localparam int AISS_SEL_A_LSB = 0;
    localparam int AISS_SEL_B_LSB = 8;
    localparam int AISS_CTRL_ALT = 0;
    localparam int AISS_CTRL_SCAN = 1;
    localparam int AISS_CTRL_AMP_LSB = 4;

    // ------------------------------------------------------------
    // positive-select codes
    // ------------------------------------------------------------
    localparam logic [4:0] AISS_CODE_AN_MAX = 5'h0F;
    localparam logic [4:0] AISS_CODE_AMP1 = 5'h18;
    localparam logic [4:0] AISS_CODE_AMP2 = 5'h19;
    localparam logic [4:0] AISS_CODE_AMP3 = 5'h1A;
    localparam logic [4:0] AISS_CODE_TEMP = 5'h1E;
    localparam logic [4:0] AISS_CODE_OPEN = 5'h1F;

    // analog route kinds driven to the multiplexer
    typedef enum logic [2:0] {
        AISS_RT_PIN = 3'h0,
        AISS_RT_AMP = 3'h1,
        AISS_RT_TEMP = 3'h3,
        AISS_RT_OPEN = 3'h2,
        AISS_RT_LOW_REF = 3'h6
    } aiss_route_t;

    // scan controller states
    typedef enum logic [1:0] {
        AISS_ST_IDLE = 2'b00,
        AISS_ST_SCAN = 2'b01
    } aiss_state_t;
endpackage

// ### verilog/aiss_decode.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// input code to analog route decoder
// ------------------------------------------------------------
module aiss_decode
    import aiss_pkg::*;
#(
    parameter int NUM_PINS = 16
)
(
    // selection
    input wire logic [4:0] code,
    input wire logic [2:0] amp_mode,
    // route
    output aiss_route_t route,
    output logic [3:0] index
);
    // decode one 5-bit code; amplifier codes fall back to the shared pin
    always_comb
    begin
        route = AISS_RT_LOW_REF;
        index = 4'h0;
        if (code <= AISS_CODE_AN_MAX)
        begin
            index = code[3:0];
            route = (32'(code) < NUM_PINS) ? AISS_RT_PIN : AISS_RT_LOW_REF;
        end
        else if (code == AISS_CODE_AMP1)
        begin
            index = amp_mode[0] ? 4'h1 : 4'h3;
            route = amp_mode[0] ? AISS_RT_AMP : AISS_RT_PIN;
        end
        else if (code == AISS_CODE_AMP2)
        begin
            index = amp_mode[1] ? 4'h2 : 4'h0;
            route = amp_mode[1] ? AISS_RT_AMP : AISS_RT_PIN;
        end
        else if (code == AISS_CODE_AMP3)
        begin
            index = amp_mode[2] ? 4'h3 : 4'h6;
            route = amp_mode[2] ? AISS_RT_AMP : AISS_RT_PIN;
        end
        else if (code == AISS_CODE_TEMP)
        begin
            route = AISS_RT_TEMP;
        end
        else if (code == AISS_CODE_OPEN)
        begin
            route = AISS_RT_OPEN;
        end
    end
endmodule
`default_nettype wire

// ### verilog/aiss_pick.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// next set bit above a position, wrapping to the lowest
// ------------------------------------------------------------
module aiss_pick
(
    // inputs
    input wire logic [31:0] mask,
    input wire logic [4:0] cur,
    // outputs
    output logic [4:0] nxt,
    output logic found
);
    // first set bit strictly above cur, else lowest set bit
    always_comb
    begin
        logic hit_above;
        logic [4:0] low;
        hit_above = 1'b0;
        low = 5'h00;
        nxt = 5'h00;
        found = 1'b0;
        for (int i = 31; i >= 0; i--)
        begin
            if (mask[i])
            begin
                low = 5'(i);
                found = 1'b1;
                if (5'(i) > cur)
                begin
                    nxt = 5'(i);
                    hit_above = 1'b1;
                end
            end
        end
        if (!hit_above)
        begin
            nxt = low;
        end
    end
endmodule
`default_nettype wire

// ### verilog/aiss_top.sv
// Summary of operation
// - codes 0..15 route analog pins 0..15
// - code 31 leaves positive input open
// - code 30 routes the temperature diode
// - codes 24,25,26 route amplifiers 1,2,3
// - amplifier used only when mode bit set
// - high bit 15 scans open node
// - high bit 14 scans temperature diode
// - high bits 10,9,8 scan amplifiers 3,2,1
// - unimplemented high bits read as zero
// - low bit x scans analog input x
// - all low bits writable; missing inputs convert low reference
// - low bits 3,0,6 reach amplifiers 1,2,3
// - alternate mode toggles first and second multiplexer
`timescale 1ns/100ps
`default_nettype none
module aiss_top
    import aiss_pkg::*;
#(
    parameter int NUM_PINS = 16
)
(
    // clock and reset
    input wire logic CLK,
    input wire logic SRST,
    // ahb-lite slave
    input wire logic HSEL,
    input wire logic [7:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // converter side
    input wire logic SAMPLE_DONE,
    input wire logic [2:0] AMP_MODE,
    // analog multiplexer drive
    output aiss_route_t MUX_ROUTE,
    output logic [3:0] MUX_INDEX,
    output logic [4:0] MUX_SCAN_POS
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [15:0] chsel_r;
    logic [15:0] scanh_r;
    logic [15:0] scanl_r;
    logic [1:0] ctrl_r;
    logic wr_pend_r;
    logic [7:0] wr_addr_r;
    logic use_b_r;
    logic [4:0] pos_r;
    aiss_state_t state_r;
    logic [2:0] amp_meta_r;
    logic [2:0] amp_r;
    logic done_meta_r;
    logic done_r;
    logic done_d_r;
    logic done_pulse;

    // ------------------------------------------------------------
    // synchronise the external inputs
    // ------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            amp_meta_r <= 3'h0;
            amp_r <= 3'h0;
            done_meta_r <= 1'b0;
            done_r <= 1'b0;
            done_d_r <= 1'b0;
        end
        else
        begin
            amp_meta_r <= AMP_MODE;
            amp_r <= amp_meta_r;
            done_meta_r <= SAMPLE_DONE;
            done_r <= done_meta_r;
            done_d_r <= done_r;
        end
    end
    assign done_pulse = done_r & ~done_d_r;

    // ------------------------------------------------------------
    // ahb-lite bus slave
    // ------------------------------------------------------------
    logic addr_ph;
    assign addr_ph = HSEL & HREADY & HTRANS[1];

    // capture write address phase, write in data phase
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end
        else
        begin
            wr_pend_r <= addr_ph & HWRITE;
            wr_addr_r <= HADDR;
        end
    end

    // register writes; every low scan bit is writable, high scan bits masked by AISS_SCANH_MASK
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            chsel_r <= AISS_RST_CHSEL;
            scanh_r <= AISS_RST_SCAN;
            scanl_r <= AISS_RST_SCAN;
            ctrl_r <= 2'b00;
        end
        else if (wr_pend_r)
        begin
            if (wr_addr_r == AISS_OFS_CHSEL)
                chsel_r <= HWDATA[15:0] & AISS_CHSEL_MASK;
            else if (wr_addr_r == AISS_OFS_SCANH)
                scanh_r <= HWDATA[15:0] & AISS_SCANH_MASK;
            else if (wr_addr_r == AISS_OFS_SCANL)
                scanl_r <= HWDATA[15:0];
            else if (wr_addr_r == AISS_OFS_CTRL)
                ctrl_r <= HWDATA[1:0];
        end
    end

    // read data, registered from the address phase
    always_ff @(posedge CLK)
    begin
        if (SRST)
            HRDATA <= 32'h0000_0000;
        else if (addr_ph & ~HWRITE)
        begin
            if (HADDR == AISS_OFS_CHSEL)
                HRDATA <= {16'h0000, chsel_r};
            else if (HADDR == AISS_OFS_SCANH)
                HRDATA <= {16'h0000, scanh_r};
            else if (HADDR == AISS_OFS_SCANL)
                HRDATA <= {16'h0000, scanl_r};
            else if (HADDR == AISS_OFS_CTRL)
                HRDATA <= {25'h0000000, amp_r, 2'b00, ctrl_r};
            else if (HADDR == AISS_OFS_STAT)
                HRDATA <= {25'h0000000, use_b_r, state_r == AISS_ST_SCAN, pos_r};
            else
                HRDATA <= 32'h0000_0000;
        end
    end

    // zero wait states, always OKAY
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end
        else
        begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // scan sequencing
    // ------------------------------------------------------------
    logic [31:0] scan_mask;
    logic [4:0] pos_nxt;
    logic pos_found;
    // combined 32-entry mask: low register then high register
    assign scan_mask = {scanh_r, scanl_r};

    aiss_pick u_pick
    (
        .mask(scan_mask),
        .cur(pos_r),
        .nxt(pos_nxt),
        .found(pos_found)
    );

    // advance one selected input per finished sample
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            state_r <= AISS_ST_IDLE;
            pos_r <= 5'h1F;
        end
        else
        begin
            case (state_r)
                AISS_ST_IDLE:
                begin
                    pos_r <= 5'h1F;
                    if (ctrl_r[AISS_CTRL_SCAN] & pos_found)
                    begin
                        state_r <= AISS_ST_SCAN;
                        pos_r <= pos_nxt;
                    end
                end
                default:
                begin
                    if (!ctrl_r[AISS_CTRL_SCAN] | !pos_found)
                        state_r <= AISS_ST_IDLE;
                    else if (done_pulse)
                        pos_r <= pos_nxt;
                end
            endcase
        end
    end

    // alternate multiplexer per sample
    always_ff @(posedge CLK)
    begin
        if (SRST)
            use_b_r <= 1'b0;
        else if (!ctrl_r[AISS_CTRL_ALT])
            use_b_r <= 1'b0;
        else if (done_pulse)
            use_b_r <= ~use_b_r;
    end

    // ------------------------------------------------------------
    // route decode and output registers
    // ------------------------------------------------------------
    logic [4:0] code_sel;
    aiss_route_t dec_route;
    logic [3:0] dec_index;

    // scan position maps: 0..15 pins, 24..26 amps, 30 temp, 31 open
    always_comb
    begin
        code_sel = use_b_r ? chsel_r[AISS_SEL_B_LSB +: 5] : chsel_r[AISS_SEL_A_LSB +: 5];
        if (state_r == AISS_ST_SCAN)
        begin
            if (pos_r <= AISS_CODE_AN_MAX)
            begin
                // pins 3, 0, 6 carry amplifiers 1, 2, 3 when in amp mode
                if (pos_r == 5'h03 && amp_r[0])
                    code_sel = AISS_CODE_AMP1;
                else if (pos_r == 5'h00 && amp_r[1])
                    code_sel = AISS_CODE_AMP2;
                else if (pos_r == 5'h06 && amp_r[2])
                    code_sel = AISS_CODE_AMP3;
                else
                    code_sel = pos_r;
            end
            else if (pos_r == 5'h1F)
                code_sel = AISS_CODE_OPEN;
            else if (pos_r == 5'h1E)
                code_sel = AISS_CODE_TEMP;
            else if (pos_r >= 5'h18 && pos_r <= 5'h1A)
                code_sel = pos_r;
            else
                code_sel = 5'h10;
        end
    end

    aiss_decode #(.NUM_PINS(NUM_PINS)) u_dec
    (
        .code(code_sel),
        .amp_mode(amp_r),
        .route(dec_route),
        .index(dec_index)
    );

    // drive the analog multiplexer from flip-flops
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            MUX_ROUTE <= AISS_RT_PIN;
            MUX_INDEX <= 4'h0;
            MUX_SCAN_POS <= 5'h00;
        end
        else
        begin
            MUX_ROUTE <= dec_route;
            MUX_INDEX <= dec_index;
            MUX_SCAN_POS <= pos_r;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_open_code;
        @(posedge CLK) disable iff (SRST)
        (state_r == AISS_ST_IDLE && !use_b_r && chsel_r[4:0] == AISS_CODE_OPEN) |=> MUX_ROUTE == AISS_RT_OPEN;
    endproperty
    a_open_code: assert property (p_open_code) else $error("open code not routed");

    property p_temp_code;
        @(posedge CLK) disable iff (SRST)
        (state_r == AISS_ST_IDLE && !use_b_r && chsel_r[4:0] == AISS_CODE_TEMP) |=> MUX_ROUTE == AISS_RT_TEMP;
    endproperty
    a_temp_code: assert property (p_temp_code) else $error("temp code not routed");

    property p_pin_code;
        @(posedge CLK) disable iff (SRST)
        (state_r == AISS_ST_IDLE && !use_b_r && chsel_r[4] == 1'b0 && 32'(chsel_r[3:0]) < NUM_PINS)
            |=> MUX_ROUTE == AISS_RT_PIN && MUX_INDEX == $past(chsel_r[3:0]);
    endproperty
    a_pin_code: assert property (p_pin_code) else $error("pin code misrouted");

    property p_amp1_mode;
        @(posedge CLK) disable iff (SRST)
        (state_r == AISS_ST_IDLE && !use_b_r && chsel_r[4:0] == AISS_CODE_AMP1)
            |=> (MUX_ROUTE == AISS_RT_AMP) == $past(amp_r[0]);
    endproperty
    a_amp1_mode: assert property (p_amp1_mode) else $error("amp1 mode ignored");

    property p_scanh_zero;
        @(posedge CLK) disable iff (SRST)
        1'b1 |-> (scanh_r & ~AISS_SCANH_MASK) == 16'h0000;
    endproperty
    a_scanh_zero: assert property (p_scanh_zero) else $error("unimplemented scan bits set");

    property p_scan_pos_sel;
        @(posedge CLK) disable iff (SRST)
        state_r == AISS_ST_SCAN |-> scan_mask[pos_r];
    endproperty
    a_scan_pos_sel: assert property (p_scan_pos_sel) else $error("scan on unselected input");

    property p_scan_step;
        @(posedge CLK) disable iff (SRST)
        (state_r == AISS_ST_SCAN && done_pulse && ctrl_r[AISS_CTRL_SCAN] && $stable(scan_mask))
            |=> pos_r == $past(pos_nxt);
    endproperty
    a_scan_step: assert property (p_scan_step) else $error("scan step wrong");

    property p_alt_toggle;
        @(posedge CLK) disable iff (SRST)
        (ctrl_r[AISS_CTRL_ALT] && done_pulse) ##1 ctrl_r[AISS_CTRL_ALT] |-> use_b_r != $past(use_b_r);
    endproperty
    a_alt_toggle: assert property (p_alt_toggle) else $error("alternate not toggling");

    property p_alt_off;
        @(posedge CLK) disable iff (SRST)
        !ctrl_r[AISS_CTRL_ALT] |=> !use_b_r;
    endproperty
    a_alt_off: assert property (p_alt_off) else $error("second mux used without alternate");

    property p_scan_amp3;
        @(posedge CLK) disable iff (SRST)
        (state_r == AISS_ST_SCAN && pos_r == 5'h06 && amp_r[2]) |=> MUX_ROUTE == AISS_RT_AMP && MUX_INDEX == 4'h3;
    endproperty
    a_scan_amp3: assert property (p_scan_amp3) else $error("amp3 not reached by scan");

    c_scan: cover property (@(posedge CLK) state_r == AISS_ST_SCAN && done_pulse);
    c_alt: cover property (@(posedge CLK) use_b_r);
    c_wrap: cover property (@(posedge CLK) state_r == AISS_ST_SCAN && done_pulse && pos_nxt < pos_r);
endmodule
`default_nettype wire

// ### verif/aiss_conv_model.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// converter behind the analog multiplexer
// ------------------------------------------------------------
module aiss_conv_model
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // conversion request and sample length in cycles
    input wire logic start,
    input wire logic [7:0] conv_len,
    // finished-sample level seen by the block
    output logic sample_done
);
    logic busy_r;
    logic [8:0] cnt_r;

    // one sample per request, then a four-cycle done window
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            busy_r <= 1'b0;
            cnt_r <= 9'h000;
        end
        else if (start && !busy_r)
        begin
            busy_r <= 1'b1;
            cnt_r <= {1'b0, conv_len} + 9'h004;
        end
        else if (busy_r)
        begin
            cnt_r <= cnt_r - 9'h001;
            if (cnt_r == 9'h001)
                busy_r <= 1'b0;
        end
    end

    // done is a level wide enough for the block's synchroniser
    assign sample_done = busy_r && (cnt_r <= 9'h004);
endmodule
`default_nettype wire

// ### verif/aiss_bench.sv
`timescale 1ns/100ps
`default_nettype none
module adc_input_select_and_scan_bench
    import aiss_pkg::*;
;
    typedef struct packed {
        logic [4:0] code;
        logic [2:0] amp;
        aiss_route_t rt;
        logic [4:0] idx;
    } aiss_bench_row_t;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic clk;
    logic srst;
    logic hsel;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [2:0] amp_mode;
    logic sample_done;
    logic conv_start;
    logic [7:0] conv_len;
    aiss_route_t mux_route;
    logic [3:0] mux_index;
    logic [4:0] mux_scan_pos;
    int bad_count;
    int cmp_count;
    aiss_bench_row_t rows [0:10];

    // twelve pins so the top codes and bits hit the low reference
    aiss_top #(.NUM_PINS(12)) aiss_top_i (
        .CLK(clk), .SRST(srst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
        .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
        .HRESP(hresp), .SAMPLE_DONE(sample_done), .AMP_MODE(amp_mode), .MUX_ROUTE(mux_route),
        .MUX_INDEX(mux_index), .MUX_SCAN_POS(mux_scan_pos)
    );
    aiss_conv_model aiss_conv_model_i (
        .clk(clk), .srst(srst), .start(conv_start), .conv_len(conv_len), .sample_done(sample_done)
    );

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic give_up();
        bad_count++;
        $display("timeout at %0t", $time);
        print_verdict();
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // index value 16 or above means the index is not looked at
    task automatic check_mux(input aiss_route_t rt, input logic [4:0] idx);
        check({29'h0, mux_route}, {29'h0, rt});
        if (idx[4] == 1'b0)
            check({28'h0, mux_index}, {28'h0, idx[3:0]});
    endtask

    // waits for the bus ready at a bounded number of edges
    task automatic wait_ready();
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1)
            give_up();
    endtask

    task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        wait_ready();
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
        q = hrdata;
    endtask

    task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus_xfer(1'b1, a, d, q);
    endtask

    // one sample from the converter, then wait for the mux to move
    task automatic convert(input logic [7:0] len);
        logic [11:0] old;
        int n;
        old = {mux_route, mux_index, mux_scan_pos};
        @(posedge clk);
        conv_len <= len;
        conv_start <= 1'b1;
        @(posedge clk);
        conv_start <= 1'b0;
        n = 0;
        while ({mux_route, mux_index, mux_scan_pos} === old && n < 400)
        begin
            @(posedge clk);
            n++;
        end
        if ({mux_route, mux_index, mux_scan_pos} === old)
            give_up();
        repeat (4) @(posedge clk);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        logic [31:0] rd;
        logic [4:0] spos [0:6];
        aiss_route_t srt [0:6];
        logic [4:0] sidx [0:6];
        srst = 1'b1;
        hsel = 1'b1;
        haddr = 8'h00;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0;
        amp_mode = 3'h0;
        conv_start = 1'b0;
        conv_len = 8'h01;
        bad_count = 0;
        cmp_count = 0;
        rows = '{'{5'h00, 3'h0, AISS_RT_PIN, 5'h00}, '{5'h0B, 3'h0, AISS_RT_PIN, 5'h0B},
                 '{5'h0C, 3'h0, AISS_RT_LOW_REF, 5'h10}, '{5'h1F, 3'h0, AISS_RT_OPEN, 5'h10},
                 '{5'h1E, 3'h0, AISS_RT_TEMP, 5'h10}, '{5'h18, 3'h1, AISS_RT_AMP, 5'h01},
                 '{5'h19, 3'h2, AISS_RT_AMP, 5'h02}, '{5'h1A, 3'h4, AISS_RT_AMP, 5'h03},
                 '{5'h18, 3'h6, AISS_RT_PIN, 5'h03}, '{5'h19, 3'h5, AISS_RT_PIN, 5'h00},
                 '{5'h1A, 3'h3, AISS_RT_PIN, 5'h06}};
        spos = '{5'h03, 5'h06, 5'h0C, 5'h1A, 5'h1E, 5'h1F, 5'h00};
        srt = '{AISS_RT_AMP, AISS_RT_AMP, AISS_RT_LOW_REF, AISS_RT_AMP, AISS_RT_TEMP, AISS_RT_OPEN, AISS_RT_PIN};
        sidx = '{5'h01, 5'h03, 5'h10, 5'h03, 5'h10, 5'h10, 5'h00};
        repeat (12) @(posedge clk);
        check_mux(AISS_RT_PIN, 5'h00);
        check({31'h0, hresp}, 32'h0);
        srst <= 1'b0;
        bus_xfer(1'b0, AISS_OFS_CHSEL, 32'h0, rd);
        check(rd, {16'h0, AISS_RST_CHSEL});
        bus_xfer(1'b0, AISS_OFS_SCANH, 32'h0, rd);
        check(rd, 32'h0000_0000);
        bus_xfer(1'b0, AISS_OFS_SCANL, 32'h0, rd);
        check(rd, 32'h0000_0000);
        $display("test reset done");

        // primary select codes with amplifier modes on and off
        for (int i = 0; i < 11; i++)
        begin
            @(posedge clk);
            amp_mode <= rows[i].amp;
            repeat (4) @(posedge clk);
            bus_write(AISS_OFS_CHSEL, {27'h0, rows[i].code});
            repeat (3) @(posedge clk);
            check_mux(rows[i].rt, rows[i].idx);
        end
        $display("test select table done");

        bus_write(AISS_OFS_SCANH, 32'hFFFF_FFFF);
        bus_xfer(1'b0, AISS_OFS_SCANH, 32'h0, rd);
        check(rd, 32'h0000_C700);
        bus_write(AISS_OFS_SCANL, 32'h0000_FFFF);
        bus_xfer(1'b0, AISS_OFS_SCANL, 32'h0, rd);
        check(rd, 32'h0000_FFFF);
        bus_write(8'h20, 32'h0000_1234);
        bus_xfer(1'b0, 8'h20, 32'h0, rd);
        check(rd, 32'h0000_0000);
        check({31'h0, hresp}, 32'h0);
        bus_xfer(1'b0, AISS_OFS_SCANL, 32'h0, rd);
        check(rd, 32'h0000_FFFF);
        $display("test scan registers done");

        // alternate mode: first code 2, second code 5
        bus_write(AISS_OFS_CHSEL, 32'h0000_0502);
        bus_write(AISS_OFS_CTRL, 32'h0000_0001);
        repeat (3) @(posedge clk);
        check_mux(AISS_RT_PIN, 5'h02);
        convert(8'h01);
        check_mux(AISS_RT_PIN, 5'h05);
        convert(8'h28);
        check_mux(AISS_RT_PIN, 5'h02);
        convert(8'h01);
        check_mux(AISS_RT_PIN, 5'h05);
        bus_write(AISS_OFS_CTRL, 32'h0000_0000);
        repeat (3) @(posedge clk);
        check_mux(AISS_RT_PIN, 5'h02);
        $display("test alternate done");

        // scan pins 0, 3, 6, absent pin 12, amplifier 3, temperature diode, open node
        @(posedge clk);
        amp_mode <= 3'b101;
        repeat (4) @(posedge clk);
        bus_write(AISS_OFS_SCANL, 32'h0000_1049);
        bus_write(AISS_OFS_SCANH, 32'h0000_C400);
        bus_write(AISS_OFS_CTRL, 32'h0000_0002);
        repeat (3) @(posedge clk);
        check({27'h0, mux_scan_pos}, 32'h0);
        check_mux(AISS_RT_PIN, 5'h00);
        for (int k = 0; k < 7; k++)
        begin
            convert((k == 1) ? 8'h30 : 8'h01);
            check({27'h0, mux_scan_pos}, {27'h0, spos[k]});
            check_mux(srt[k], sidx[k]);
        end
        bus_xfer(1'b0, AISS_OFS_STAT, 32'h0, rd);
        check(rd, 32'h0000_0020);
        bus_xfer(1'b0, AISS_OFS_CTRL, 32'h0, rd);
        check(rd, 32'h0000_0052);
        $display("test scan done");

        // reset again in mid-run, while scanning
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        check_mux(AISS_RT_PIN, 5'h00);
        check({27'h0, mux_scan_pos}, 32'h0);
        srst <= 1'b0;
        bus_xfer(1'b0, AISS_OFS_SCANL, 32'h0, rd);
        check(rd, {16'h0, AISS_RST_SCAN});
        $display("test mid-run reset done");
        print_verdict();
    end
endmodule
`default_nettype wire
